//--- wdr_watchdog.sv
// Watchdog timer with reset cause, reached as an AHB-Lite slave.
// Assumes hclk is the counting clock and that the system reset network
// takes wdr_sys_rst_n and the interrupt controller takes wdr_irq.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps

module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // System outputs
  output logic wdr_sys_rst_n,
  output logic wdr_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Register state
  logic [31:0] count_r, count_nxt;
  logic [31:0] reload_r, reload_nxt;
  logic [5:0] ctrl_r, ctrl_nxt;
  logic zero_flag_r, zero_flag_nxt;
  logic [1:0] cause_r, cause_nxt;
  logic [15:0] pulse_len_r, pulse_len_nxt;
  logic [WDR_EV_BITS-1:0] irq_stat_r, irq_stat_nxt;
  logic [WDR_EV_BITS-1:0] irq_mask_r, irq_mask_nxt;
  logic [2:0] presc_r, presc_nxt;
  wdr_state_e state_r, state_nxt;
  logic [15:0] pulse_cnt_r, pulse_cnt_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic rd_wait_r, rd_wait_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic sys_rst_n_r, sys_rst_n_nxt;
  // Decode and event nets
  logic bus_take;
  logic word_ok;
  logic wr_now;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic [2:0] div_last;
  logic tick;
  logic count_en;
  logic mode1_act;
  logic hit;
  logic key_ok;
  logic key_bad;
  logic do_restart;
  logic fire_reset;
  logic [WDR_EV_BITS-1:0] ev_set;
  logic [WDR_EV_BITS-1:0] ev_clr;
  logic [31:0] rd_mux;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************

  // Address phase accepted when selected, active and bus ready
  // Writes never wait; only a read inserts its one wait state
  assign bus_take = hsel & hready & (htrans == WDR_HTRANS_NONSEQ | htrans == WDR_HTRANS_SEQ);
  assign word_ok = (hsize == WDR_HSIZE_WORD);
  assign wr_now = wr_pend_r;
  assign wr_ofs = 8'(addr_r);
  // Mux decodes only while a read is pending, and rests on zero
  assign rd_ofs = rd_pend_r ? 8'(addr_r) : 8'h00;

  // Read mux over the live register values
  always_comb begin
    rd_mux = 32'h00000000;
    case (rd_ofs)
      WDR_OFS_COUNT: rd_mux = count_r;
      WDR_OFS_RELOAD: rd_mux = reload_r;
      WDR_OFS_CTRL: rd_mux = {26'h0000000, ctrl_r};
      WDR_OFS_FLAG: rd_mux = {31'h00000000, zero_flag_r};
      WDR_OFS_CAUSE: rd_mux = {30'h00000000, cause_r};
      WDR_OFS_PULSE_LEN: rd_mux = {16'h0000, pulse_len_r};
      WDR_OFS_IRQ_STAT: rd_mux = {{(32 - WDR_EV_BITS){1'b0}}, irq_stat_r};
      WDR_OFS_IRQ_MASK: rd_mux = {{(32 - WDR_EV_BITS){1'b0}}, irq_mask_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Bus phase tracking; reads take one wait state so that a read
  // right behind a write sees the written value
  always_comb begin
    wr_pend_nxt = wr_pend_r;
    rd_pend_nxt = rd_pend_r;
    rd_wait_nxt = rd_wait_r;
    addr_nxt = addr_r;
    rdata_nxt = rdata_r;
    if (rd_wait_r) begin
      rdata_nxt = rd_mux;
      rd_wait_nxt = 1'b0;
    end else if (hready) begin
      wr_pend_nxt = 1'b0;
      rd_pend_nxt = 1'b0;
      if (bus_take) begin
        addr_nxt = haddr;
        wr_pend_nxt = hwrite & word_ok;
        rd_pend_nxt = ~hwrite;
        rd_wait_nxt = ~hwrite;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r <= '0;
      rdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_wait_r <= rd_wait_nxt;
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hreadyout = ~rd_wait_r;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // ****************************************************************
  // Prescaler and expiry decode
  // ****************************************************************

  // divide by 1, 2, 4 or 8
  assign div_last = 3'((4'h1 << ctrl_r[WDR_CTRL_PRESC_HI:WDR_CTRL_PRESC_LO]) - 4'h1);
  assign count_en = ctrl_r[WDR_CTRL_COUNT_EN];
  assign tick = count_en & (presc_r == div_last);

  // Prescaler restarts with each restart or when stopped
  // so the first tick after enabling is always a full period
  always_comb begin
    presc_nxt = presc_r;
    if (!count_en || do_restart || state_r == WDR_ST_PULSE) begin
      presc_nxt = 3'h0;
    end else if (tick) begin
      presc_nxt = 3'h0;
    end else begin
      presc_nxt = presc_r + 3'h1;
    end
  end

  // Mode 1 behaviour needs all three enables set
  assign mode1_act = ctrl_r[WDR_CTRL_MODE] & ctrl_r[WDR_CTRL_RST_EN] & ctrl_r[WDR_CTRL_IRQ_EN];
  // zero reached on the step to 0, or on a tick while at 0
  // A held zero in mode 0 repeats the hit on every tick
  assign hit = tick & (count_r <= 32'h00000001) & (state_r == WDR_ST_RUN);

  // exact key restarts, anything else is rejected
  // Key is compared in the data phase, where hwdata stands
  assign key_ok = wr_now & (wr_ofs == WDR_OFS_KEY) & (hwdata == WDR_RESTART_KEY);
  assign key_bad = wr_now & (wr_ofs == WDR_OFS_KEY) & (hwdata != WDR_RESTART_KEY);
  assign do_restart = key_ok;

  // Decide whether this expiry issues a system reset
  always_comb begin
    fire_reset = 1'b0;
    if (hit) begin
      if (mode1_act) begin
        // second zero with flag still set resets
        fire_reset = zero_flag_r;
      end else begin
        fire_reset = ctrl_r[WDR_CTRL_RST_EN];
      end
    end
  end

  // ****************************************************************
  // Counter and software registers
  // ****************************************************************

  always_comb begin
    count_nxt = count_r;
    reload_nxt = reload_r;
    ctrl_nxt = ctrl_r;
    zero_flag_nxt = zero_flag_r;
    if (state_r == WDR_ST_PULSE) begin
      // watchdog reset returns these to defaults
      // Forced every pulse cycle, so a bus write then is lost
      count_nxt = WDR_COUNT_RST;
      reload_nxt = WDR_RELOAD_RST;
      ctrl_nxt = WDR_CTRL_RST;
      zero_flag_nxt = 1'b0;
    end else begin
      if (tick && count_r != 32'h00000000) begin
        count_nxt = count_r - 32'h00000001;
      end
      // mode 1 reloads and keeps counting
      if (hit && mode1_act && !fire_reset) begin
        count_nxt = reload_r;
      end
      // key write copies reload into count
      if (do_restart) begin
        count_nxt = reload_r;
      end
      if (wr_now && wr_ofs == WDR_OFS_RELOAD) begin
        reload_nxt = hwdata;
      end
      if (wr_now && wr_ofs == WDR_OFS_CTRL) begin
        ctrl_nxt = hwdata[5:0];
      end
      if (wr_now && wr_ofs == WDR_OFS_FLAG_CLR) begin
        zero_flag_nxt = 1'b0;
      end
      // set wins over a same-cycle clear
      if (hit) begin
        zero_flag_nxt = 1'b1;
      end
    end
  end

  // count and reload defaults on power-on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= WDR_COUNT_RST;
      reload_r <= WDR_RELOAD_RST;
      ctrl_r <= WDR_CTRL_RST;
      zero_flag_r <= 1'b0;
      presc_r <= 3'h0;
    end else begin
      count_r <= count_nxt;
      reload_r <= reload_nxt;
      ctrl_r <= ctrl_nxt;
      zero_flag_r <= zero_flag_nxt;
      presc_r <= presc_nxt;
    end
  end

  // ****************************************************************
  // Reset cause and pulse length, kept through watchdog reset
  // ****************************************************************

  always_comb begin
    cause_nxt = cause_r;
    pulse_len_nxt = pulse_len_r;
    if (wr_now && wr_ofs == WDR_OFS_CAUSE) begin
      cause_nxt = hwdata[1:0];
    end
    // hardware set wins over software clear
    // A watchdog reset never clears it; only hresetn or a bus write to CAUSE does
    if (fire_reset) begin
      cause_nxt[WDR_CAUSE_WDOG] = 1'b1;
    end
    if (wr_now && wr_ofs == WDR_OFS_PULSE_LEN) begin
      pulse_len_nxt = hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_r <= 2'h0;
      pulse_len_r <= WDR_PULSE_LEN_RST;
    end else begin
      cause_r <= cause_nxt;
      pulse_len_r <= pulse_len_nxt;
    end
  end

  // ****************************************************************
  // Reset pulse sequencer
  // ****************************************************************

  // one low pulse of pulse_len cycles, at least one
  // Length taken at entry; a write during the pulse counts next time
  always_comb begin
    state_nxt = state_r;
    pulse_cnt_nxt = pulse_cnt_r;
    sys_rst_n_nxt = 1'b1;
    case (state_r)
      WDR_ST_RUN: begin
        if (fire_reset) begin
          state_nxt = WDR_ST_PULSE;
          pulse_cnt_nxt = (pulse_len_r == 16'h0000) ? 16'h0001 : pulse_len_r;
          sys_rst_n_nxt = 1'b0;
        end
      end
      WDR_ST_PULSE: begin
        // width equals register value in clocks
        if (pulse_cnt_r == 16'h0001) begin
          state_nxt = WDR_ST_RUN;
          pulse_cnt_nxt = 16'h0000;
        end else begin
          pulse_cnt_nxt = pulse_cnt_r - 16'h0001;
          sys_rst_n_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = WDR_ST_RUN;
        pulse_cnt_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= WDR_ST_RUN;
      pulse_cnt_r <= 16'h0000;
      sys_rst_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      sys_rst_n_r <= sys_rst_n_nxt;
    end
  end

  assign wdr_sys_rst_n = sys_rst_n_r;

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************

  // Events: expiry without reset, rejected key write
  assign ev_set[WDR_EV_EXPIRE] = hit & ~fire_reset;
  assign ev_set[WDR_EV_BAD_KEY] = key_bad & (state_r == WDR_ST_RUN);
  assign ev_clr = (wr_now && wr_ofs == WDR_OFS_IRQ_STAT) ? hwdata[WDR_EV_BITS-1:0] : '0;

  // Write one to clear, set wins
  // Cleared with the mask while the pulse runs, like other soft state
  always_comb begin
    irq_stat_nxt = (irq_stat_r & ~ev_clr) | ev_set;
    irq_mask_nxt = irq_mask_r;
    if (state_r == WDR_ST_PULSE) begin
      irq_stat_nxt = '0;
      irq_mask_nxt = '0;
    end else if (wr_now && wr_ofs == WDR_OFS_IRQ_MASK) begin
      irq_mask_nxt = hwdata[WDR_EV_BITS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // zero flag with irq enabled drives the interrupt
  // stands until the flag is cleared
  // Unmasked events share the line with the expiry level
  assign wdr_irq = (zero_flag_r & ctrl_r[WDR_CTRL_IRQ_EN]) | (|(irq_stat_r & irq_mask_r));

endmodule // wdr_watchdog

//--- wdr_pkg.sv
// Constants, register map and field layout of the watchdog with reset cause.
// Assumes a single AHB-Lite clock domain; all offsets are byte addresses.
package wdr_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] WDR_OFS_COUNT = 8'h94;
  localparam logic [7:0] WDR_OFS_RELOAD = 8'h98;
  localparam logic [7:0] WDR_OFS_KEY = 8'h9C;
  localparam logic [7:0] WDR_OFS_CTRL = 8'hA0;
  localparam logic [7:0] WDR_OFS_FLAG = 8'hA4;
  localparam logic [7:0] WDR_OFS_FLAG_CLR = 8'hA8;
  localparam logic [7:0] WDR_OFS_CAUSE = 8'hAC;
  localparam logic [7:0] WDR_OFS_PULSE_LEN = 8'hB0;
  localparam logic [7:0] WDR_OFS_IRQ_STAT = 8'hB4;
  localparam logic [7:0] WDR_OFS_IRQ_MASK = 8'hB8;

  // ****************************************************************
  // Reset values and key
  // ****************************************************************
  localparam logic [31:0] WDR_COUNT_RST = 32'h05B8D800;
  localparam logic [31:0] WDR_RELOAD_RST = 32'h05B8D800;
  localparam logic [15:0] WDR_PULSE_LEN_RST = 16'h00FF;
  localparam logic [5:0] WDR_CTRL_RST = 6'h00;
  // Restart password; the value is arbitrary
  localparam logic [31:0] WDR_RESTART_KEY = 32'h3C5A96E1;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int WDR_CTRL_COUNT_EN = 0;
  localparam int WDR_CTRL_RST_EN = 1;
  localparam int WDR_CTRL_IRQ_EN = 2;
  localparam int WDR_CTRL_MODE = 3;
  localparam int WDR_CTRL_PRESC_LO = 4;
  localparam int WDR_CTRL_PRESC_HI = 5;
  localparam int WDR_CAUSE_WDOG = 0;
  localparam int WDR_CAUSE_SOFT = 1;
  localparam int WDR_EV_EXPIRE = 0;
  localparam int WDR_EV_BAD_KEY = 1;
  localparam int WDR_EV_BITS = 2;

  // ****************************************************************
  // Bus encodings
  // ****************************************************************
  localparam logic [1:0] WDR_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] WDR_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] WDR_HSIZE_WORD = 3'h2;

  // Reset pulse sequencer states
  typedef enum logic [1:0] {
    WDR_ST_RUN = 2'b01,
    WDR_ST_PULSE = 2'b10
  } wdr_state_e;

endpackage

//--- wdr_watchdog_sva.sv
// Checker of bus timing and reset pulse of the watchdog.
// Assumes one hclk domain; bound to every wdr_watchdog instance.
`timescale 1ns/1ps

module wdr_watchdog_sva
  import wdr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // System outputs
  input wire logic wdr_sys_rst_n,
  input wire logic wdr_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_go;
  logic wr_go;
  logic plen_wr_r, plen_wr_nxt;
  logic [15:0] plen_r, plen_nxt, low_r, low_nxt;
  // Accepted address phases
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;
  // Shadow of pulse length, count of low cycles
  always_comb begin
    plen_wr_nxt = wr_go && hsize == WDR_HSIZE_WORD && haddr[7:0] == WDR_OFS_PULSE_LEN;
    plen_nxt = (plen_wr_r && hready) ? hwdata[15:0] : plen_r;
    low_nxt = wdr_sys_rst_n ? 16'h0000 : low_r + 16'h0001;
  end
  // Helper registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      plen_wr_r <= 1'b0;
      plen_r <= WDR_PULSE_LEN_RST;
      low_r <= 16'h0000;
    end else begin
      plen_wr_r <= plen_wr_nxt;
      plen_r <= plen_nxt;
      low_r <= low_nxt;
    end
  end
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  AST_READ_WAIT: assert property (rd_go |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (wr_go |=> hreadyout)
    else $error("write stalled");
  AST_LOW_CAUSE: assert property (!hreadyout |-> $past(rd_go))
    else $error("wait state without read");
  AST_WRITE_KEEPS_DATA: assert property (wr_go |=> $stable(hrdata))
    else $error("read data moved on write");
  AST_PULSE_LEN: assert property ($rose(wdr_sys_rst_n) |->
    low_r == ((plen_r == 16'h0000) ? 16'h0001 : plen_r))
    else $error("reset pulse width wrong");
  AST_PULSE_CLEARS_IRQ: assert property ($fell(wdr_sys_rst_n) |-> ##2 !wdr_irq)
    else $error("irq kept through reset");
  AST_PULSE_SINGLE: assert property ($rose(wdr_sys_rst_n) |=> wdr_sys_rst_n [*2])
    else $error("second reset pulse");
  AST_RESET_IDLE: assert property ($rose(hresetn) |-> hreadyout && wdr_sys_rst_n && !wdr_irq)
    else $error("outputs not idle after reset");
endmodule // wdr_watchdog_sva

bind wdr_watchdog wdr_watchdog_sva #(.ADDR_W(ADDR_W)) wdr_watchdog_sva_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .wdr_sys_rst_n(wdr_sys_rst_n), .wdr_irq(wdr_irq)
);

//--- wdr_watchdog_tb.sv
// Self-checking bench of the watchdog over AHB-Lite.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps

module wdr_watchdog_tb
  import wdr_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} wdr_row_s;
  // ********
  // Signals
  // ********
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wdr_sys_rst_n, wdr_irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd_s, x;
  logic rdy_s;
  int errors, checks_done, cycles, n, d, rst_lows, rst_base;
  // Register rows: writes carry data, reads the expected value
  wdr_row_s rows [22] = '{
    '{1'b0, WDR_OFS_COUNT, WDR_COUNT_RST}, '{1'b0, WDR_OFS_RELOAD, WDR_RELOAD_RST},
    '{1'b0, WDR_OFS_CTRL, 32'h0}, '{1'b0, WDR_OFS_FLAG, 32'h0},
    '{1'b0, WDR_OFS_CAUSE, 32'h0}, '{1'b0, WDR_OFS_PULSE_LEN, 32'hFF},
    '{1'b0, WDR_OFS_IRQ_STAT, 32'h0}, '{1'b0, WDR_OFS_IRQ_MASK, 32'h0},
    '{1'b0, 8'h00, 32'h0}, '{1'b1, WDR_OFS_RELOAD, 32'h12345678},
    '{1'b0, WDR_OFS_RELOAD, 32'h12345678}, '{1'b1, WDR_OFS_COUNT, 32'h0},
    '{1'b0, WDR_OFS_COUNT, WDR_COUNT_RST}, '{1'b1, WDR_OFS_CTRL, 32'h3C},
    '{1'b0, WDR_OFS_CTRL, 32'h3C}, '{1'b1, WDR_OFS_KEY, WDR_RESTART_KEY},
    '{1'b0, WDR_OFS_COUNT, 32'h12345678}, '{1'b1, WDR_OFS_CAUSE, 32'h2},
    '{1'b0, WDR_OFS_CAUSE, 32'h2}, '{1'b1, WDR_OFS_PULSE_LEN, 32'h4},
    '{1'b0, WDR_OFS_PULSE_LEN, 32'h4}, '{1'b1, WDR_OFS_CTRL, 32'h0}
  };
  // Bus ready is the one slave's ready
  assign hready = hreadyout;
  wdr_watchdog #(.ADDR_W(8)) wdr_watchdog_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wdr_sys_rst_n(wdr_sys_rst_n), .wdr_irq(wdr_irq)
  );
  // Clock of 40 ns
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Settled bus values, seen mid-cycle
  always @(negedge hclk) begin
    rdy_s = hready;
    rd_s = hrdata;
    if (!wdr_sys_rst_n) rst_lows++;
  end
  // Hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report;
    end
  end
  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single transfer, request held until ready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [2:0] sz, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= WDR_HTRANS_NONSEQ;
    hsize <= sz;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    rd = rd_s;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] dt);
    logic [31:0] r;
    xfer(1'b1, a, dt, WDR_HSIZE_WORD, r);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, WDR_HSIZE_WORD, r);
    check(r, e);
  endtask
  task automatic irq_is(input logic e);
    @(negedge hclk);
    check({31'h0, wdr_irq}, {31'h0, e});
    @(posedge hclk);
  endtask
  // Count cycles until irq (sel 0) or reset out (sel 1) shows v
  task automatic wait_lvl(input logic sel, input logic v, output int cnt);
    logic cur;
    cnt = 0;
    do begin
      @(negedge hclk);
      cnt++;
      cur = sel ? wdr_sys_rst_n : wdr_irq;
    end while (cur !== v && cnt < 400);
    @(posedge hclk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = WDR_HSIZE_WORD;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wreg(rows[i].a, rows[i].d);
      else rchk(rows[i].a, rows[i].d);
    end
    xfer(1'b1, WDR_OFS_RELOAD, 32'hAAAA5555, 3'h0, x);
    rchk(WDR_OFS_RELOAD, 32'h12345678);
    // Expiry time for every divider code
    for (int p = 0; p < 4; p++) begin
      d = 1 << p;
      wreg(WDR_OFS_RELOAD, 32'h8);
      wreg(WDR_OFS_KEY, WDR_RESTART_KEY);
      wreg(WDR_OFS_CTRL, {26'h0, p[1:0], 4'h5});
      wait_lvl(1'b0, 1'b1, n);
      check(32'(n >= 7 * d && n <= 8 * d + 2), 32'h1);
      rchk(WDR_OFS_FLAG, 32'h1);
      wreg(WDR_OFS_CTRL, 32'h4);
      irq_is(1'b1);
      wreg(WDR_OFS_FLAG_CLR, 32'h0);
      irq_is(1'b0);
    end
    // Status, mask and clear of the event interrupts
    rchk(WDR_OFS_IRQ_STAT, 32'h1);
    wreg(WDR_OFS_IRQ_STAT, 32'h3);
    wreg(WDR_OFS_CTRL, 32'h0);
    wreg(WDR_OFS_KEY, 32'h0);
    rchk(WDR_OFS_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    rchk(WDR_OFS_COUNT, 32'h0);
    wreg(WDR_OFS_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    wreg(WDR_OFS_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    // Mode 0 reset and what survives it
    wreg(WDR_OFS_KEY, WDR_RESTART_KEY);
    wreg(WDR_OFS_CTRL, 32'h3);
    wait_lvl(1'b1, 1'b0, n);
    wait_lvl(1'b1, 1'b1, n);
    check(32'(n), 32'h4);
    rchk(WDR_OFS_CTRL, 32'h0);
    rchk(WDR_OFS_RELOAD, WDR_RELOAD_RST);
    rchk(WDR_OFS_COUNT, WDR_COUNT_RST);
    rchk(WDR_OFS_CAUSE, 32'h3);
    rchk(WDR_OFS_PULSE_LEN, 32'h4);
    // Mode 1: cleared flag gives irq, kept flag gives reset
    wreg(WDR_OFS_RELOAD, 32'h28);
    wreg(WDR_OFS_KEY, WDR_RESTART_KEY);
    rst_base = rst_lows;
    wreg(WDR_OFS_CTRL, 32'hF);
    wait_lvl(1'b0, 1'b1, n);
    wreg(WDR_OFS_FLAG_CLR, 32'h1);
    irq_is(1'b0);
    wait_lvl(1'b0, 1'b1, n);
    check(32'(rst_lows == rst_base && n > 30 && n < 45), 32'h1);
    wait_lvl(1'b1, 1'b0, n);
    check(32'(n < 60), 32'h1);
    wait_lvl(1'b1, 1'b1, n);
    // Power-on reset in mid-run
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(WDR_OFS_CAUSE, 32'h0);
    rchk(WDR_OFS_PULSE_LEN, 32'hFF);
    final_report;
  end
endmodule // wdr_watchdog_tb
